/* File: hw/ppc_cfg.svh */
// Constants for the parallel I/O device controller.
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
`define PPC_SEL_PORT_A    2'h0
`define PPC_SEL_PORT_B    2'h1
`define PPC_SEL_PORT_C    2'h2
`define PPC_SEL_CONTROL   2'h3
`define PPC_CW_MODE_BIT   7
`define PPC_CW_BITSEL_HI  3
`define PPC_CW_BITSEL_LO  1
`define PPC_CW_BITVAL     0
`define PPC_CW_DIR_A      4
`define PPC_CW_DIR_CU     3
`define PPC_CW_DIR_B      1
`define PPC_CW_DIR_CL     0
`define PPC_CW_MODE0_ALL  8'h80
`define PPC_SETUP_NS      30
`define PPC_PULSE_NS      300
`define PPC_RECOVER_NS    1000
`define PPC_CLK_NS        4
`define PPC_SETUP_CYC     ((`PPC_SETUP_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_PULSE_CYC     ((`PPC_PULSE_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_RECOVER_CYC   ((`PPC_RECOVER_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`endif

/* File: hw/ppc_pkg.sv */
// Types for the parallel I/O device controller.
package ppc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_STROBE  = 3'b010,
    ST_HOLD    = 3'b011,
    ST_RECOVER = 3'b100
  } ppc_state_e;
  typedef enum logic [1:0] {
    OP_WRITE  = 2'b00,
    OP_READ   = 2'b01,
    OP_BITSR  = 2'b10,
    OP_MODE   = 2'b11
  } ppc_op_e;
endpackage

/* File: hw/ppc_sync.sv */
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module ppc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;
  // Only the second stage is read outside; the first settles metastability.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* File: hw/ppc_host.sv */
// Host controller that drives the parallel I/O device over its bus pins.
//
// Function
// - Drive chip select low for every access.
// - Present port select with the strobe.
// - Never read control address; bus floats idle.
// - One control write sets any mode.
// - Upper C outputs via port C writes or bit set/reset.
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_host #(
  parameter int SETUP_CYC   = `PPC_SETUP_CYC,
  parameter int PULSE_CYC   = `PPC_PULSE_CYC,
  parameter int RECOVER_CYC = `PPC_RECOVER_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       req_valid_i,
  input  wire logic [1:0] req_op_i,
  input  wire logic [1:0] req_port_i,
  input  wire logic [7:0] req_data_i,
  input  wire logic [2:0] req_bit_i,
  output logic            req_ready_o,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            req_error_o,
  output logic            dev_reset_o,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            port_select_lo_o,
  output logic            port_select_hi_o,
  input  wire logic [7:0] dbus_i,
  output logic [7:0]      dbus_o,
  output logic            dbus_oe_o
);
  // Read data crosses two sync flops, so a strobe shorter than three cycles samples stale data;
  // the 10-bit counter bounds every count from above.
  if (SETUP_CYC < 1 || PULSE_CYC < 3 || RECOVER_CYC < 1 ||
      RECOVER_CYC > 1023 || PULSE_CYC > 1023 || SETUP_CYC > 1023) begin : g_bad_timing
    $error("ppc_host: timing counts out of range");
  end

  typedef struct packed {
    ppc_pkg::ppc_state_e state;
    logic [9:0]          cnt;
    logic                is_read;
    logic [1:0]          sel;
    logic [7:0]          wdata;
    logic                ready;
    logic                rsp_valid;
    logic [7:0]          rsp_data;
    logic                error;
    logic                dev_reset;
    logic                cs_n;
    logic                rd_n;
    logic                wr_n;
    logic                oe;
  } ppc_host_s;

  ppc_host_s r;
  ppc_host_s next_r;
  logic [7:0] dbus_sync;

  // Read data comes from the device pins, so it is synchronised first.
  ppc_sync #(.W(8)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .async_i   (dbus_i),
    .sync_o    (dbus_sync)
  );

  // Sequencer: setup, strobe pulse, hold, then recovery before the next access.
  always_comb begin
    next_r           = r;
    next_r.rsp_valid = 1'b0;
    next_r.error     = 1'b0;
    case (r.state)
      ppc_pkg::ST_IDLE: begin
        next_r.dev_reset = 1'b0;
        if (req_valid_i && r.ready) begin
          next_r.ready   = 1'b0;
          next_r.cnt     = 10'(SETUP_CYC);
          next_r.is_read = 1'b0;
          next_r.wdata   = req_data_i;
          next_r.sel     = req_port_i;
          case (ppc_pkg::ppc_op_e'(req_op_i))
            ppc_pkg::OP_READ: begin
              next_r.is_read = 1'b1;
              if (req_port_i == `PPC_SEL_CONTROL) begin
                // Control register is write only; refuse locally.
                next_r.error = 1'b1;
                next_r.ready = 1'b1;
              end
            end
            ppc_pkg::OP_BITSR: begin
              next_r.sel   = `PPC_SEL_CONTROL;
              next_r.wdata = {4'h0, req_bit_i, req_data_i[0]};
            end
            ppc_pkg::OP_MODE: begin
              next_r.sel   = `PPC_SEL_CONTROL;
              next_r.wdata = req_data_i | `PPC_CW_MODE0_ALL;
            end
            default: begin
              // Port C writes are legal and outputs in both nibbles follow.
              next_r.sel = req_port_i;
            end
          endcase
          if (!(next_r.is_read && req_port_i == `PPC_SEL_CONTROL)) begin
            next_r.state = ppc_pkg::ST_SETUP;
            next_r.cs_n  = 1'b0;
            next_r.oe    = !next_r.is_read;
          end
        end
      end
      ppc_pkg::ST_SETUP: begin
        // Address and select stand before the strobe falls.
        if (r.cnt <= 10'h001) begin
          next_r.state = ppc_pkg::ST_STROBE;
          next_r.cnt   = 10'(PULSE_CYC);
          next_r.rd_n  = !r.is_read;
          next_r.wr_n  = r.is_read;
        end else begin
          next_r.cnt = r.cnt - 10'h001;
        end
      end
      ppc_pkg::ST_STROBE: begin
        if (r.cnt <= 10'h001) begin
          // Data is sampled just before the read strobe rises.
          if (r.is_read) begin
            next_r.rsp_data = dbus_sync;
          end
          next_r.state = ppc_pkg::ST_HOLD;
          next_r.rd_n  = 1'b1;
          next_r.wr_n  = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 10'h001;
        end
      end
      ppc_pkg::ST_HOLD: begin
        // One hold cycle keeps data and address past the strobe's rise.
        next_r.state     = ppc_pkg::ST_RECOVER;
        next_r.cs_n      = 1'b1;
        next_r.oe        = 1'b0;
        next_r.cnt       = 10'(RECOVER_CYC);
        next_r.rsp_valid = 1'b1;
      end
      ppc_pkg::ST_RECOVER: begin
        if (r.cnt <= 10'h001) begin
          next_r.state = ppc_pkg::ST_IDLE;
          next_r.ready = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 10'h001;
        end
      end
      default: begin
        next_r.state = ppc_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; controller reset loads device reset high, and it drops on the first clock after release.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r           <= '0;
      r.state     <= ppc_pkg::ST_IDLE;
      r.ready     <= 1'b1;
      r.dev_reset <= 1'b1;
      r.cs_n      <= 1'b1;
      r.rd_n      <= 1'b1;
      r.wr_n      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign req_ready_o      = r.ready;
  assign rsp_valid_o      = r.rsp_valid;
  assign rsp_data_o       = r.rsp_data;
  assign req_error_o      = r.error;
  assign dev_reset_o      = r.dev_reset;
  assign cs_n_o           = r.cs_n;
  assign rd_n_o           = r.rd_n;
  assign wr_n_o           = r.wr_n;
  assign port_select_lo_o = r.sel[0];
  assign port_select_hi_o = r.sel[1];
  assign dbus_o           = r.wdata;
  assign dbus_oe_o        = r.oe;

  // Strobes only while chip select is low.
  a_strobe_needs_cs: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!rd_n_o || !wr_n_o) |-> !cs_n_o) else $error("strobe without chip select");
  a_no_dual_strobe: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(!rd_n_o && !wr_n_o)) else $error("read and write together");
  a_no_ctrl_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !rd_n_o |-> {port_select_hi_o, port_select_lo_o} != `PPC_SEL_CONTROL)
    else $error("read of control address");
  a_bus_off_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !rd_n_o |-> !dbus_oe_o) else $error("bus driven during read");
  a_write_drives: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !wr_n_o |-> dbus_oe_o) else $error("write without bus drive");
  a_sel_stable: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!wr_n_o && !$past(wr_n_o)) |-> $stable({port_select_hi_o, port_select_lo_o, dbus_o}))
    else $error("address or data moved under write");
  a_single_commit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(wr_n_o) |=> wr_n_o [*2]) else $error("write strobe repeated");
  a_bitsr_form: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!wr_n_o && {port_select_hi_o, port_select_lo_o} == `PPC_SEL_CONTROL) |->
    (dbus_o[7] || dbus_o[6:4] == 3'h0)) else $error("malformed control word");
  a_response_after: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(rd_n_o) |=> rsp_valid_o) else $error("missing response");

  c_read: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(rd_n_o));
  c_write: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(wr_n_o));
  c_error: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) req_error_o);
endmodule

/* File: sim/ppc_dev_model.sv */
// Behavioural model of the parallel I/O device that the host controller drives.
`timescale 1ns/1ps
module ppc_dev_model #(
  parameter logic [7:0] PINS_A = 8'hA5,
  parameter logic [7:0] PINS_B = 8'h96,
  parameter logic [7:0] PINS_C = 8'hC3
) (
  input  wire logic       reset_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [7:0] dbus_i,
  input  wire logic [1:0] irq_pending_i,
  output logic      [7:0] dbus_o,
  output logic      [1:0] irq_request_out_o
);
  logic [1:0] mode_a;
  logic       mode_b;
  logic [1:0] irq_gate_flop;
  logic [3:0] dir;
  logic [7:0] lat_a;
  logic [7:0] lat_b;
  logic [7:0] lat_c;
  logic [7:0] rd_val;
  logic [7:0] last = 8'h00;
  // Writes land on the rising write strobe, so a long strobe still commits once.
  always @(posedge reset_i or posedge wr_n_i) begin
    if (reset_i) begin
      dir <= 4'hF;
      lat_a <= 8'h00;
      lat_b <= 8'h00;
      lat_c <= 8'h00;
      mode_a <= 2'h0;
      mode_b <= 1'b0;
      irq_gate_flop <= 2'h0;
    end else if (!cs_n_i) begin
      case (sel_i)
        2'h0: lat_a <= dbus_i;
        2'h1: lat_b <= dbus_i;
        2'h2: lat_c <= dbus_i;
        default: begin
          if (dbus_i[7]) begin
            dir <= {dbus_i[4], dbus_i[3], dbus_i[1], dbus_i[0]};
            lat_a <= 8'h00;
            lat_b <= 8'h00;
            lat_c <= 8'h00;
            mode_a <= dbus_i[6:5];
            mode_b <= dbus_i[2];
            irq_gate_flop <= 2'h0;
          end else begin
            lat_c[dbus_i[3:1]] <= dbus_i[0];
            // Gate flops only exist while their group runs a strobed mode.
            if (dbus_i[3:1] == 3'h4 && mode_a != 2'h0) irq_gate_flop[1] <= dbus_i[0];
            if (dbus_i[3:1] == 3'h2 && mode_b) irq_gate_flop[0] <= dbus_i[0];
          end
        end
      endcase
    end
  end
  // Input ports read the pins live; only output ports come from the latches.
  always_comb begin
    case (sel_i)
      2'h0: rd_val = dir[3] ? PINS_A : lat_a;
      2'h1: rd_val = dir[1] ? PINS_B : lat_b;
      2'h2: rd_val = {dir[2] ? PINS_C[7:4] : lat_c[7:4],
                      dir[0] ? PINS_C[3:0] : lat_c[3:0]};
      default: rd_val = ~last;
    endcase
  end
  // A released bus shows the inverse of its last value, so stale data never matches.
  always @(posedge rd_n_i) last <= rd_val;
  assign dbus_o = (!cs_n_i && !rd_n_i) ? rd_val : ~last;
  // A pending request reaches its output only through its gate flop.
  assign irq_request_out_o = irq_gate_flop & irq_pending_i & {mode_a != 2'h0, mode_b};
endmodule

/* File: sim/tb.sv */
// Self-checking testbench for the parallel I/O host controller.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] PA = 8'hA5;
  localparam logic [7:0] PB = 8'h96;
  localparam logic [7:0] PC = 8'hC3;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i;
  logic [1:0] irq_pend  = 2'h3;
  logic [1:0] irq;
  logic       vld       = 1'b0;
  logic [1:0] op        = 2'h0;
  logic [1:0] prt       = 2'h0;
  logic [7:0] dat       = 8'h00;
  logic [2:0] bsel      = 3'h0;
  logic       rdy, rsp, err, drst, cs_n, rd_n, wr_n, s_lo, s_hi, oe, got_err, saw_cs;
  logic [7:0] rdat, d_h, d_d, dbus, mw;
  int         num_errors = 0;
  int         num_checks = 0;
  assign dbus = oe ? d_h : d_d;
  ppc_host #(.SETUP_CYC(1), .PULSE_CYC(4), .RECOVER_CYC(2)) dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_valid_i(vld), .req_op_i(op),
    .req_port_i(prt), .req_data_i(dat), .req_bit_i(bsel), .req_ready_o(rdy),
    .rsp_valid_o(rsp), .rsp_data_o(rdat), .req_error_o(err), .dev_reset_o(drst),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .port_select_lo_o(s_lo),
    .port_select_hi_o(s_hi), .dbus_i(dbus), .dbus_o(d_h), .dbus_oe_o(oe));
  ppc_dev_model #(.PINS_A(PA), .PINS_B(PB), .PINS_C(PC)) dev (
    .reset_i(drst), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .sel_i({s_hi, s_lo}), .dbus_i(dbus), .irq_pending_i(irq_pend), .dbus_o(d_d),
    .irq_request_out_o(irq));
  // Free-running system clock.
  always #2 clk_sys_i = ~clk_sys_i;
  // Compare one byte and count it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One request: hold it until taken, then wait for the answer; both waits are bounded.
  task automatic req(input logic [1:0] o, input logic [1:0] p, input logic [7:0] d,
                     input logic [2:0] b);
    int n;
    @(posedge clk_sys_i);
    vld <= 1'b1;
    op <= o;
    prt <= p;
    dat <= d;
    bsel <= b;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (rdy !== 1'b1 && n < 500);
    if (rdy !== 1'b1) begin
      num_errors++;
      $display("[FAIL] t=%0t request never taken", $time);
      final_report();
    end
    @(posedge clk_sys_i);
    vld <= 1'b0;
    got_err = 1'b0;
    saw_cs = 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
      if (cs_n === 1'b0) saw_cs = 1'b1;
      if (err === 1'b1) got_err = 1'b1;
    end while (rsp !== 1'b1 && err !== 1'b1 && n < 500);
    if (rsp !== 1'b1 && err !== 1'b1) begin
      num_errors++;
      $display("[FAIL] t=%0t no answer", $time);
      final_report();
    end
  endtask
  initial begin
    // Starting from unknown gives the asynchronous reset a real falling edge.
    rstn_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    // After reset every port is an input and reads return the pins.
    req(2'h1, 2'h0, 8'h00, 3'h0);
    chk(rdat, PA);
    chk({7'h0, saw_cs}, 8'h01);
    req(2'h1, 2'h2, 8'h00, 3'h0);
    chk(rdat, PC);
    $display("test reset_defaults done");
    // All sixteen mode 0 direction mixes, outputs written with one pattern.
    for (int i = 0; i < 16; i++) begin
      mw = {3'b100, i[3], i[2], 1'b0, i[1], i[0]};
      req(2'h3, 2'h3, mw, 3'h0);
      for (int p = 0; p < 3; p++) req(2'h0, p[1:0], 8'h3C, 3'h0);
      req(2'h1, 2'h0, 8'h00, 3'h0);
      chk(rdat, i[3] ? PA : 8'h3C);
      req(2'h1, 2'h1, 8'h00, 3'h0);
      chk(rdat, i[1] ? PB : 8'h3C);
      req(2'h1, 2'h2, 8'h00, 3'h0);
      chk(rdat, {i[2] ? PC[7:4] : 4'h3, i[0] ? PC[3:0] : 4'hC});
    end
    $display("test mode0_mixes done");
    // Single port C bits change alone.
    req(2'h3, 2'h3, 8'h80, 3'h0);
    req(2'h0, 2'h2, 8'h00, 3'h0);
    req(2'h2, 2'h2, 8'h01, 3'h5);
    req(2'h2, 2'h2, 8'h01, 3'h0);
    req(2'h2, 2'h2, 8'h00, 3'h5);
    req(2'h1, 2'h2, 8'h00, 3'h0);
    chk(rdat, 8'h01);
    $display("test bit_set_reset done");
    // A mode write clears the output latches.
    req(2'h0, 2'h0, 8'hFF, 3'h0);
    req(2'h3, 2'h3, 8'h80, 3'h0);
    req(2'h1, 2'h0, 8'h00, 3'h0);
    chk(rdat, 8'h00);
    $display("test mode_clears done");
    // A read of the control address is refused with no bus cycle.
    req(2'h1, 2'h3, 8'h00, 3'h0);
    chk({7'h0, got_err}, 8'h01);
    chk({7'h0, saw_cs}, 8'h00);
    $display("test control_read done");
    // Interrupt gates: set and cleared by bit writes, cleared by mode writes and reset.
    req(2'h3, 2'h3, 8'hA4, 3'h0);
    chk({6'h0, irq}, 8'h00);
    req(2'h2, 2'h2, 8'h01, 3'h4);
    chk({6'h0, irq}, 8'h02);
    req(2'h2, 2'h2, 8'h01, 3'h2);
    chk({6'h0, irq}, 8'h03);
    @(posedge clk_sys_i);
    irq_pend <= 2'h2;
    @(negedge clk_sys_i);
    chk({6'h0, irq}, 8'h02);
    irq_pend <= 2'h3;
    req(2'h2, 2'h2, 8'h00, 3'h4);
    chk({6'h0, irq}, 8'h01);
    req(2'h3, 2'h3, 8'hA4, 3'h0);
    chk({6'h0, irq}, 8'h00);
    req(2'h2, 2'h2, 8'h01, 3'h4);
    chk({6'h0, irq}, 8'h02);
    // Mid-run reset returns the device to all inputs with gates cleared.
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    chk({6'h0, irq}, 8'h00);
    req(2'h1, 2'h0, 8'h00, 3'h0);
    chk(rdat, PA);
    $display("test irq_gates done");
    final_report();
  end
endmodule
